// ### hw/cpu_status_and_option_regs.v
// Status and option registers of a small 8-bit core, with AXI4-Lite access
// Behaviour
// - Flag-updating op into status ignores written Z, DC, C; result sets them
// - Time-out and power-down flags are read-only to writes
// - Clearing status zeroes bank bits, sets Z, keeps other flags
// - Indirect bank bit selects banks 2,3 or banks 0,1
// - Two direct bank bits select one of four 128-byte banks
// - Time-out flag set at power-up, watchdog clear, sleep; cleared on time-out
// - Power-down flag set at power-up or watchdog clear; cleared on sleep
// - Zero flag follows whether the arithmetic or logic result is zero
// - Nibble carry reflects carry out of bit 3 for add and subtract
// - Carry reflects carry out of the top bit for add and subtract
// - Subtract adds two's complement, so carries act as inverted borrows
// - Rotates load carry with the bit shifted out of the source
// - Pull-up disable bit kills all pull-ups, else port latches decide
// - Edge select picks rising or falling edge on external interrupt pin
// - Clock source select picks external pin or instruction clock for timer
// - Timer edge select picks falling or rising external transitions
// - Rate code n divides timer by 2^(n+1) or watchdog by 2^n
`timescale 1ns/1ps
`include "cpu_status_regs.vh"

module cpu_status_and_option_regs (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        awvalid,
  output reg         awready,
  input  wire [31:0] awaddr,
  input  wire [2:0]  awprot,
  input  wire        wvalid,
  output reg         wready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  output reg         bvalid,
  input  wire        bready,
  output reg  [1:0]  bresp,
  input  wire        arvalid,
  output reg         arready,
  input  wire [31:0] araddr,
  input  wire [2:0]  arprot,
  output reg         rvalid,
  input  wire        rready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  input  wire        wdt_timeout,
  input  wire        wdt_raw_tick,
  input  wire        timer_ext_clock_pin,
  input  wire        ext_irq_pin,
  input  wire [5:0]  port_latch,
  input  wire [6:0]  direct_offset,
  input  wire [7:0]  indirect_pointer,
  output reg  [5:0]  pullup_en,
  output reg         ext_irq_event,
  output reg         timer_tick,
  output reg         wdt_tick,
  output reg  [8:0]  direct_addr,
  output reg  [8:0]  indirect_addr
);

  // ==========================================
  // Register state
  reg  [7:0]  status;
  reg  [7:0]  option;
  reg  [19:0] alu_op;
  reg  [7:0]  alu_result;
  reg         aw_got;
  reg         w_got;
  reg  [4:0]  aw_ofs;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;

  // ==========================================
  // Write decode
  // Address and data may arrive in either order; nothing moves until both are held
  wire        do_write  = aw_got && w_got && !bvalid;
  wire        lane0     = w_strb[0];
  wire        wr_status = do_write && lane0 && aw_ofs == `OFS_STATUS;
  wire        wr_option = do_write && lane0 && aw_ofs == `OFS_OPTION;
  wire        wr_cmd    = do_write && lane0 && aw_ofs == `OFS_COMMAND;
  wire        wr_alu    = do_write && lane0 && aw_ofs == `OFS_ALU_OP;
  wire        wr_ok     = aw_ofs == `OFS_STATUS || aw_ofs == `OFS_OPTION ||
                          aw_ofs == `OFS_COMMAND || aw_ofs == `OFS_ALU_OP;
  wire        clr_stat  = wr_cmd && w_data[`CMD_CLR_STATUS];
  wire        wdt_clr   = wr_cmd && w_data[`CMD_WDT_CLEAR];
  wire        sleep_op  = wr_cmd && w_data[`CMD_SLEEP];

  // ==========================================
  // ALU on the operation being written
  wire [7:0]  op_a    = w_data[`ALU_A_LO +: 8];
  wire [7:0]  op_b    = w_data[`ALU_B_LO +: 8];
  wire [2:0]  op_code = w_data[`ALU_CODE_LO +: 3];
  wire        to_stat = w_data[`ALU_DEST_STATUS];
  wire        is_sub  = op_code == `ALU_SUB;
  wire [7:0]  addend  = is_sub ? ~op_b : op_b;
  wire [8:0]  sum     = {1'b0, op_a} + {1'b0, addend} + {8'h00, is_sub};
  wire [4:0]  nib     = {1'b0, op_a[3:0]} + {1'b0, addend[3:0]} + {4'h0, is_sub};
  reg  [7:0]  res;
  reg         nz;
  reg         ndc;
  reg         nc;

  always @* begin
    res = sum[7:0];
    nz  = status[`ST_Z];
    ndc = status[`ST_DC];
    nc  = status[`ST_C];
    case (op_code)
      `ALU_ADD, `ALU_SUB: begin
        res = sum[7:0];
        nz  = sum[7:0] == 8'h00;
        ndc = nib[4];
        nc  = sum[8];
      end
      `ALU_AND: begin
        res = op_a & op_b;
        nz  = res == 8'h00;
      end
      `ALU_OR: begin
        res = op_a | op_b;
        nz  = res == 8'h00;
      end
      `ALU_XOR: begin
        res = op_a ^ op_b;
        nz  = res == 8'h00;
      end
      `ALU_RRF: begin
        res = {status[`ST_C], op_a[7:1]};
        nc  = op_a[0];
      end
      `ALU_RLF: begin
        res = {op_a[6:0], status[`ST_C]};
        nc  = op_a[7];
      end
      default: begin
        // Plain move leaves every flag as it was unless its data is written into status
        res = op_a;
      end
    endcase
  end

  // ==========================================
  // Status register
  reg [7:0] next_status;

  always @* begin
    next_status = status;
    if (wr_status) begin
      // Reset-cause bits never take written data
      next_status[7:5] = w_data[7:5];
      next_status[2:0] = w_data[2:0];
    end
    if (wr_alu) begin
      if (to_stat) begin
        next_status[7:5] = res[7:5];
        next_status[2:0] = res[2:0];
      end
      // Flag-changing ops override the written flags; a plain move keeps its data
      if (op_code != `ALU_MOVE) begin
        next_status[`ST_Z]  = nz;
        next_status[`ST_DC] = ndc;
        next_status[`ST_C]  = nc;
      end
    end
    if (clr_stat) begin
      next_status[7:5]   = 3'h0;
      next_status[`ST_Z] = 1'b1;
    end
    // Clearing events first so a same-cycle set wins
    if (wdt_timeout)
      next_status[`ST_TO] = 1'b0;
    if (sleep_op)
      next_status[`ST_PD] = 1'b0;
    if (wdt_clr || sleep_op)
      next_status[`ST_TO] = 1'b1;
    if (wdt_clr)
      next_status[`ST_PD] = 1'b1;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      status     <= `STATUS_RESET;
      option     <= `OPTION_RESET;
      alu_op     <= 20'h00000;
      alu_result <= 8'h00;
    end else begin
      status <= next_status;
      if (wr_option)
        option <= w_data[7:0];
      if (wr_alu) begin
        alu_op     <= w_data[19:0];
        alu_result <= res;
      end
    end
  end

  // ==========================================
  // AXI4-Lite write channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= `RESP_OKAY;
      aw_got  <= 1'b0;
      w_got   <= 1'b0;
      aw_ofs  <= 5'h00;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        aw_got  <= 1'b1;
        // Upper address bits outside the map make the offset miss
        aw_ofs  <= (awaddr[31:5] == 27'h0) ? awaddr[4:0] : 5'h1f;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        w_got  <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end
      if (do_write) begin
        bvalid <= 1'b1;
        // Misses answer with an error instead of aliasing onto a real register
        if (wr_ok)
          bresp <= `RESP_OKAY;
        else
          bresp <= `RESP_SLVERR;
        aw_got <= 1'b0;
        w_got  <= 1'b0;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // ==========================================
  // AXI4-Lite read channel
  // Read data is captured at the address take, so it shows the registers then
  reg [31:0] rd_word;
  reg        rd_ok;

  always @* begin
    rd_ok   = araddr[31:5] == 27'h0;
    rd_word = 32'h00000000;
    case (araddr[4:0])
      `OFS_STATUS:     rd_word = {24'h000000, status};
      `OFS_OPTION:     rd_word = {24'h000000, option};
      `OFS_COMMAND:    rd_word = 32'h00000000;
      `OFS_ALU_OP:     rd_word = {12'h000, alu_op};
      `OFS_ALU_RESULT: rd_word = {24'h000000, alu_result};
      default:         rd_ok   = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= `RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        if (rd_ok) begin
          rdata <= rd_word;
          rresp <= `RESP_OKAY;
        end else begin
          rdata <= 32'h00000000;
          rresp <= `RESP_SLVERR;
        end
      end
      if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // ==========================================
  // Bank addressing and pull-ups
  // Outputs lag their sources by one cycle so that each comes from a flop
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : pull
      always @(posedge aclk) begin
        if (!aresetn)
          pullup_en[gi] <= 1'b0;
        else
          pullup_en[gi] <= !option[`OP_PULLUP_DISABLE_BIT] && port_latch[gi];
      end
    end
  endgenerate

  always @(posedge aclk) begin
    if (!aresetn) begin
      direct_addr   <= 9'h000;
      indirect_addr <= 9'h000;
    end else begin
      direct_addr   <= {status[`ST_RP_HI], status[`ST_RP_LO], direct_offset};
      indirect_addr <= {status[`ST_IRP], indirect_pointer};
    end
  end

  // ==========================================
  // External interrupt edge and timer source
  reg        irq_prev;
  reg        tck_prev;
  reg        edge_armed;
  reg [1:0]  instr_div;
  // Previous samples are trusted only once taken out of reset, so a pin
  // that idles high cannot fake an edge on the first cycle
  wire       tck_rise = edge_armed && timer_ext_clock_pin && !tck_prev;
  wire       tck_fall = edge_armed && !timer_ext_clock_pin && tck_prev;
  wire       ext_evt  = option[`OP_TIMER_EDGE_SEL] ? tck_fall : tck_rise;
  wire       instr_evt = {30'h0, instr_div} == `INSTR_DIV - 1;
  wire       tmr_src  = option[`OP_TIMER_CLOCK_SOURCE_SEL] ? ext_evt : instr_evt;

  // ==========================================
  // Shared prescaler
  // One counter only: timer and watchdog cannot both be divided at once
  reg  [7:0] pre_cnt;
  wire       to_wdt   = option[`OP_PSA];
  wire [3:0] rate     = {1'b0, option[`OP_PS_HI:`OP_PS_LO]};
  wire [3:0] taps     = to_wdt ? rate : rate + 4'h1;
  // Timer rate 7 shifts the bit out, and the wrap gives the full mask
  wire [7:0] one_hot  = 8'h01 << taps;
  wire [7:0] mask     = one_hot - 8'h01;
  wire       pre_src  = to_wdt ? wdt_raw_tick : tmr_src;
  wire       pre_fire = pre_src && ((pre_cnt & mask) == mask);

  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_prev      <= 1'b0;
      tck_prev      <= 1'b0;
      edge_armed    <= 1'b0;
      instr_div     <= 2'h0;
      pre_cnt       <= 8'h00;
      ext_irq_event <= 1'b0;
      timer_tick    <= 1'b0;
      wdt_tick      <= 1'b0;
    end else begin
      irq_prev      <= ext_irq_pin;
      tck_prev      <= timer_ext_clock_pin;
      edge_armed    <= 1'b1;
      instr_div     <= instr_div + 2'h1;
      if (!edge_armed)
        ext_irq_event <= 1'b0;
      else if (option[`OP_EXT_IRQ_EDGE_SEL])
        ext_irq_event <= ext_irq_pin && !irq_prev;
      else
        ext_irq_event <= !ext_irq_pin && irq_prev;
      // Reassigning the prescaler restarts its count
      if (wr_option)
        pre_cnt <= 8'h00;
      else if (pre_src)
        pre_cnt <= pre_cnt + 8'h01;
      if (to_wdt) begin
        timer_tick <= tmr_src;
        wdt_tick   <= pre_fire;
      end else begin
        timer_tick <= pre_fire;
        wdt_tick   <= wdt_raw_tick;
      end
    end
  end

endmodule

// ### shared/cpu_status_regs.vh
// Register offsets, field positions, reset values and codes for the status/option bank
`ifndef CPU_STATUS_REGS_VH
`define CPU_STATUS_REGS_VH

// ==========================================
// Register byte offsets
`define OFS_STATUS      5'h00
`define OFS_OPTION      5'h04
`define OFS_COMMAND     5'h08
`define OFS_ALU_OP      5'h0c
`define OFS_ALU_RESULT  5'h10

// ==========================================
// Status fields
`define ST_IRP          7
`define ST_RP_HI        6
`define ST_RP_LO        5
`define ST_TO           4
`define ST_PD           3
`define ST_Z            2
`define ST_DC           1
`define ST_C            0
`define STATUS_RESET    8'h18

// ==========================================
// Option fields
`define OP_PULLUP_DISABLE_BIT         7
`define OP_EXT_IRQ_EDGE_SEL       6
`define OP_TIMER_CLOCK_SOURCE_SEL         5
`define OP_TIMER_EDGE_SEL         4
`define OP_PSA          3
`define OP_PS_HI        2
`define OP_PS_LO        0
`define OPTION_RESET    8'hff

// ==========================================
// Command bits
`define CMD_CLR_STATUS  0
`define CMD_WDT_CLEAR   1
`define CMD_SLEEP       2

// ==========================================
// ALU operation register layout and codes
`define ALU_A_LO        0
`define ALU_B_LO        8
`define ALU_CODE_LO     16
`define ALU_DEST_STATUS 19
`define ALU_ADD         3'h0
`define ALU_SUB         3'h1
`define ALU_AND         3'h2
`define ALU_OR          3'h3
`define ALU_XOR         3'h4
`define ALU_RRF         3'h5
`define ALU_RLF         3'h6
`define ALU_MOVE        3'h7

// ==========================================
// Timing
`define INSTR_DIV       4

// ==========================================
// AXI responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// ### testbench/cpu_status_and_option_regs_monitor.sv
// Concurrent checks on the status and option register bank ports
`timescale 1ns/1ps
module cpu_status_and_option_regs_monitor (
  input wire       aclk,
  input wire       aresetn,
  input wire       awvalid,
  input wire       awready,
  input wire       wvalid,
  input wire       wready,
  input wire       bvalid,
  input wire       bready,
  input wire [1:0] bresp,
  input wire       arvalid,
  input wire       arready,
  input wire       rvalid,
  input wire       ext_irq_pin,
  input wire       ext_irq_event,
  input wire [5:0] port_latch,
  input wire [6:0] direct_offset,
  input wire [7:0] indirect_pointer,
  input wire [5:0] pullup_en,
  input wire [8:0] direct_addr,
  input wire [8:0] indirect_addr
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========
  // Bus handshakes
  property p_wr_ans; awvalid && awready && wvalid && wready |-> ##2 bvalid; endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write not answered");
  property p_rd_ans; arvalid && arready |=> rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_rst;
    $rose(aresetn) |-> awready && wready && arready && !bvalid && !rvalid
      && pullup_en == 6'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  // ==========
  // Pin relations; guarded since reset holds outputs at zero
  property p_dir; $past(aresetn) |-> direct_addr[6:0] == $past(direct_offset); endproperty
  a_dir: assert property (p_dir) else $error("direct offset wrong");
  property p_ind;
    $past(aresetn) |-> indirect_addr[7:0] == $past(indirect_pointer);
  endproperty
  a_ind: assert property (p_ind) else $error("indirect pointer wrong");
  property p_pull; $past(aresetn) |-> (pullup_en & ~$past(port_latch)) == 6'h00; endproperty
  a_pull: assert property (p_pull) else $error("pull-up without latch");
  property p_irq;
    ext_irq_event |-> $past(ext_irq_pin) != $past(ext_irq_pin, 2)
      || $past(ext_irq_pin, 2) != $past(ext_irq_pin, 3);
  endproperty
  a_irq: assert property (p_irq) else $error("event without pin edge");
  c_wr_err: cover property (bvalid && bresp == 2'h2);
  c_irq: cover property (ext_irq_event);
  c_bank3: cover property (direct_addr[8:7] == 2'h3);
endmodule
bind cpu_status_and_option_regs cpu_status_and_option_regs_monitor mon (.*);

// ### testbench/cpu_status_and_option_regs_tb.sv
// Self-checking bench for the status and option register bank
`timescale 1ns/1ps
`include "cpu_status_regs.vh"
module cpu_status_and_option_regs_tb;
  reg         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  reg  [31:0] awaddr, wdata, araddr, d, op;
  reg  [3:0]  wstrb;
  reg  [2:0]  awprot, arprot;
  reg         wdt_timeout, wdt_raw_tick, timer_ext_clock_pin, ext_irq_pin;
  reg  [5:0]  port_latch;
  reg  [6:0]  direct_offset;
  reg  [7:0]  indirect_pointer, st;
  reg         b_late;
  wire        awready, wready, bvalid, arready, rvalid, ext_irq_event, timer_tick, wdt_tick;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [5:0]  pullup_en;
  wire [8:0]  direct_addr, indirect_addr;
  integer     mismatches, checked, seed, n_irq, n_tmr, n_wdt, i, k;

  cpu_status_and_option_regs DUT (.*);

  initial begin
    aclk = 0;
    forever #50 aclk = ~aclk;
  end
  // Raw watchdog tick every second cycle, so rates stay short
  always @(posedge aclk) begin
    wdt_raw_tick <= aresetn & ~wdt_raw_tick;
    if (!aresetn) begin
      n_irq <= 0;
      n_tmr <= 0;
      n_wdt <= 0;
    end else begin
      n_irq <= n_irq + ext_irq_event;
      n_tmr <= n_tmr + timer_tick;
      n_wdt <= n_wdt + wdt_tick;
    end
  end
  // ==========
  // Tasks
  task chk(input [31:0] seen, input [31:0] exp, input [8*6-1:0] what);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("Error %0s exp %h seen %h", what, exp, seen);
      end
    end
  endtask
  task wr(input [31:0] a, input [31:0] v, input [1:0] er);
    begin
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= !b_late;
      do begin
        @(posedge aclk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        if (bvalid && !bready) bready <= 1'b1;
      end while (!(bvalid === 1'b1 && bready === 1'b1));
      bready <= 1'b0;
      chk(bresp, er, "bresp");
    end
  endtask
  task rd(input [31:0] a, input [31:0] ev, input [1:0] er, input [8*6-1:0] w);
    begin
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
        @(posedge aclk);
        if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk(rdata, ev, w);
      chk(rresp, er, "rresp");
    end
  endtask
  task pin(input t, input v);
    begin
      @(posedge aclk);
      if (t) timer_ext_clock_pin <= v;
      else ext_irq_pin <= v;
      repeat (5) @(posedge aclk);
    end
  endtask
  task edges(input t, input rise);
    begin
      pin(t, 1'b0);
      k = t ? n_tmr : n_irq;
      pin(t, 1'b1);
      chk((t ? n_tmr : n_irq) - k, rise, "edge_r");
      k = t ? n_tmr : n_irq;
      pin(t, 1'b0);
      chk((t ? n_tmr : n_irq) - k, !rise, "edge_f");
    end
  endtask
  // Expected {result, status}; rotate carry-in is the old carry
  function [15:0] model(input [7:0] s, input [19:0] o);
    reg [8:0] t;
    reg [4:0] h;
    reg [7:0] b, r;
    reg [2:0] m;
    begin
      b = o[16] ? ~o[15:8] : o[15:8];
      t = o[7:0] + b + o[16];
      h = o[3:0] + b[3:0] + o[16];
      m = 3'b100;
      case (o[18:16])
        `ALU_ADD, `ALU_SUB: begin
          r = t[7:0];
          m = 3'b111;
        end
        `ALU_AND: r = o[7:0] & o[15:8];
        `ALU_OR: r = o[7:0] | o[15:8];
        `ALU_XOR: r = o[7:0] ^ o[15:8];
        `ALU_RRF: begin
          r = {s[0], o[7:1]};
          t[8] = o[0];
          m = 3'b001;
        end
        `ALU_RLF: begin
          r = {o[6:0], s[0]};
          t[8] = o[7];
          m = 3'b001;
        end
        default: begin
          r = o[7:0];
          m = 3'b000;
        end
      endcase
      if (o[19]) s = {r[7:5], s[4:3], (m == 3'b000) ? r[2:0] : s[2:0]};
      model = {r, s[7:3], (s[2:0] & ~m) | ({r == 8'h0, h[4], t[8]} & m)};
    end
  endfunction
  task print_verdict;
    begin
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    #6000000;
    mismatches = mismatches + 1;
    print_verdict;
  end
  // ==========
  // Main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, wdt_timeout} = 7'h00;
    {awaddr, wdata, araddr, awprot, arprot, timer_ext_clock_pin, ext_irq_pin} = 0;
    {port_latch, direct_offset, indirect_pointer} = 0;
    wstrb = 4'hf;
    b_late = 1'b0;
    {mismatches, checked} = 0;
    seed = 22107;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`OFS_STATUS, 32'h18, 2'h0, "st_rst");
    rd(`OFS_OPTION, 32'hff, 2'h0, "op_rst");
    rd(32'h14, 32'h0, 2'h2, "unmap");
    wr(32'h18, 32'hff, 2'h2);
    wr(`OFS_STATUS, 32'hff, 2'h0);
    // Lane 0 off: the write is accepted but changes nothing
    wstrb <= 4'he;
    wr(`OFS_STATUS, 32'h0, 2'h0);
    wstrb <= 4'hf;
    rd(`OFS_STATUS, 32'hff, 2'h0, "st_ff");
    wr(`OFS_STATUS, 32'h0, 2'h0);
    rd(`OFS_STATUS, 32'h18, 2'h0, "st_ro");
    $display("register map test done");
    wr(`OFS_COMMAND, 32'h4, 2'h0);
    rd(`OFS_STATUS, 32'h10, 2'h0, "sleep");
    @(posedge aclk) wdt_timeout <= 1'b1;
    @(posedge aclk) wdt_timeout <= 1'b0;
    rd(`OFS_STATUS, 32'h0, 2'h0, "tmo");
    wr(`OFS_STATUS, 32'he3, 2'h0);
    wr(`OFS_COMMAND, 32'h1, 2'h0);
    rd(`OFS_STATUS, 32'h07, 2'h0, "clr");
    wr(`OFS_COMMAND, 32'h2, 2'h0);
    rd(`OFS_STATUS, 32'h1f, 2'h0, "wdclr");
    $display("command test done");
    for (i = 0; i < 4; i = i + 1) begin
      op = $random(seed);
      direct_offset <= op[14:8];
      indirect_pointer <= op[23:16];
      wr(`OFS_STATUS, {24'h0, op[7], i[1:0], 5'h1f}, 2'h0);
      repeat (2) @(posedge aclk);
      chk(direct_addr, {23'h0, i[1:0], op[14:8]}, "dir_a");
      chk(indirect_addr, {23'h0, op[7], op[23:16]}, "ind_a");
    end
    st = {op[7], 7'h7f};
    $display("bank test done");
    // Every code first, then carry and zero corners, then random
    for (i = 0; i < 40; i = i + 1) begin
      op = $random(seed) & 32'hfffff;
      if (i < 8) op[18:16] = i[2:0];
      if (i == 8) op = 32'h001ff;
      if (i == 9) op = 32'h95555;
      d = model(st, op[19:0]);
      st = d[7:0];
      b_late = i[0];
      wr(`OFS_ALU_OP, op, 2'h0);
      rd(`OFS_ALU_RESULT, {24'h0, d[15:8]}, 2'h0, "alu_r");
      rd(`OFS_STATUS, {24'h0, st}, 2'h0, "alu_st");
    end
    b_late = 1'b0;
    rd(`OFS_ALU_OP, {12'h0, op[19:0]}, 2'h0, "alu_op");
    rd(`OFS_COMMAND, 32'h0, 2'h0, "cmd_rd");
    $display("alu test done");
    for (i = 0; i < 4; i = i + 1) begin
      op = $random(seed);
      port_latch <= op[5:0];
      wr(`OFS_OPTION, {24'h0, ~i[0], i[0], 1'b1, i[0], 4'h8}, 2'h0);
      edges(1'b0, i[0]);
      edges(1'b1, ~i[0]);
      chk(pullup_en, i[0] ? {26'h0, port_latch} : 32'h0, "pullup");
    end
    // Windows of whole periods give exact tick counts
    for (i = 0; i < 16; i = i + 1) begin
      wr(`OFS_OPTION, {24'h0, 4'h8, i[3:0]}, 2'h0);
      k = i[3] ? 2 << i[2:0] : 8 << i[2:0];
      repeat (k) @(posedge aclk);
      d = n_tmr;
      op = n_wdt;
      repeat (4 * k) @(posedge aclk);
      chk(n_tmr - d, i[3] ? k : 4, "tmr_rt");
      if (i[3]) chk(n_wdt - op, 4, "wdt_rt");
    end
    $display("option test done");
    print_verdict;
  end
endmodule
